// ---- hdl/scqm_regs.svh ----
`ifndef SCQM_REGS_SVH
`define SCQM_REGS_SVH
// Purpose : constants of the single-carrier qam modulator
// Assumes : included by bare name
// Notes   : the block has no software registers
`define SCQM_BSR_HZ     67500
`define SCQM_CSTEP_HZ   (`SCQM_BSR_HZ / 2)
`define SCQM_OSR        4
`define SCQM_NSYM       8
`define SCQM_NTAP       32
`define SCQM_CTR        16'h0010
`define SCQM_QTR        5'h10
`define SCQM_QTR6       6'h10
`define SCQM_LUT_LG     6
`define SCQM_TAP_SH     7
`define SCQM_BP_SH      1
`define SCQM_DEN_MUL    12'h008
`define SCQM_RES_ROOM   5'h08
`define SCQM_BYTE_BITS  5'h08
`define SCQM_BUF_DEPTH  2'h2
`define SCQM_Q_KEEP     2'h0
`define SCQM_Q_CCW      2'h1
`define SCQM_Q_HALF     2'h2
`define SCQM_Q_CW       2'h3
// srrc, alpha 0.2, four samples per symbol, peak 127, index 31 first
`define SCQM_TAPS {8'h00, 8'hfb, 8'hf9, 8'hff, 8'h03, 8'h0a, 8'h0d, 8'h06, \
  8'hf7, 8'hea, 8'he8, 8'hfa, 8'h1e, 8'h4c, 8'h71, 8'h7f, 8'h71, 8'h4c, 8'h1e, \
  8'hfa, 8'he8, 8'hea, 8'hf7, 8'h06, 8'h0d, 8'h0a, 8'h03, 8'hff, 8'hf9, 8'hfb, \
  8'h00, 8'hfe}
// quarter cosine, 64 points per turn, index 16 first
`define SCQM_COSQ {8'h00, 8'h0c, 8'h19, 8'h25, 8'h31, 8'h3c, 8'h47, 8'h51, \
  8'h5a, 8'h62, 8'h6a, 8'h70, 8'h75, 8'h7a, 8'h7d, 8'h7e, 8'h7f}
`endif

// ---- hdl/scqm_pkg.sv ----
// Purpose : types of the single-carrier qam modulator
// Assumes : nothing
// Notes   : configuration is static while running
package scqm_pkg;
  typedef enum logic [0:0] {
    SCQM_PASSBAND = 1'b0,
    SCQM_BASEBAND = 1'b1
  } scqm_mode_t;
  typedef struct packed {
    scqm_mode_t  mode;
    logic [3:0]  bits_per_sym;
    logic [7:0]  rate_mult;
    logic [9:0]  carrier_mult;
    logic [15:0] sample_div;
  } scqm_cfg_t;
  typedef struct packed {
    logic signed [4:0] i;
    logic signed [4:0] q;
  } scqm_sym_t;
  typedef logic signed [15:0] scqm_sample_t;
endpackage

// ---- hdl/scqm_modulator.sv ----
`include "scqm_regs.svh"

// Purpose : single-carrier qam transmit modulator, passband or baseband shaping
// Assumes : cfg static while running; clk is the sample master
// Notes   : one sample per divider tick, held off by output back-pressure

module scqm_modulator
  import scqm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire scqm_cfg_t    cfg,
  input  wire logic         in_valid,
  input  wire logic [7:0]   in_data,
  output logic              in_ready,
  output logic              out_valid,
  output scqm_sample_t      out_data,
  input  wire logic         out_ready,
  output logic              underrun
);

  localparam int                            OSR  = `SCQM_OSR;
  localparam int                            NSYM = `SCQM_NSYM;
  localparam logic [1:0]                    PH_LAST = 2'(OSR - 1);
  localparam logic [`SCQM_NTAP-1:0][7:0]    TAPS = `SCQM_TAPS;
  localparam logic [16:0][7:0]              COSQ = `SCQM_COSQ;

  function automatic logic signed [7:0] cos_of(input logic [5:0] x);
    logic [4:0]        r;
    logic signed [7:0] v;
    r = x[4] ? `SCQM_QTR - 5'(x[3:0]) : 5'(x[3:0]);
    v = $signed(COSQ[r]);
    return (x[5] ^ x[4]) ? -v : v;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // sample tick
  // ************************************************************
  logic [15:0] div_cnt;
  logic        tick;
  logic        tick_pend;
  logic        step;
  logic        buf_in_ready;
  logic [1:0]  phase;
  logic        sym_load;

  assign tick     = (div_cnt == '0);
  // a full buffer holds the whole chain, so no sample is dropped
  assign step     = tick_pend && buf_in_ready;
  assign sym_load = step && (phase == PH_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= tick ? cfg.sample_div - 16'h0001 : div_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_pend <= 1'b0;
    end else if (tick) begin
      tick_pend <= 1'b1;
    end else if (step) begin
      tick_pend <= 1'b0;
    end
  end

  // one symbol every OSR samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else if (step) begin
      phase <= sym_load ? '0 : phase + 2'h1;
    end
  end

  a_tick_kept: assert property (tick_pend && !step |=> tick_pend)
    else $error("pending sample tick lost");

  // ************************************************************
  // bit reservoir
  // ************************************************************
  logic [15:0] res;
  logic [4:0]  res_n;
  logic [4:0]  next_res_n;
  logic [3:0]  m_bits;
  logic        short;
  logic        take;
  logic        load;
  logic [4:0]  sh;
  logic [15:0] res_sh;
  logic [7:0]  grp_al;

  assign m_bits   = cfg.bits_per_sym;
  assign in_ready = (res_n <= `SCQM_RES_ROOM);
  assign load     = in_valid && in_ready;
  assign short    = (res_n < 5'(m_bits));
  assign take     = sym_load && !short;
  assign sh       = res_n - 5'(m_bits);
  assign res_sh   = res >> sh;
  // oldest bit lands on bit 7, so b1 b2 sit at the top
  assign grp_al   = res_sh[7:0] << (4'h8 - m_bits);
  assign next_res_n = (take ? sh : res_n) + (load ? `SCQM_BYTE_BITS : 5'h00);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res   <= '0;
      res_n <= '0;
    end else begin
      if (load) begin
        res <= {res[7:0], in_data};
      end
      res_n <= next_res_n;
    end
  end

  // an empty reservoir sends a silent symbol rather than stalling the line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      underrun <= 1'b0;
    end else begin
      underrun <= sym_load && short;
    end
  end

  sequence s_lone_byte;
    load && res_n == '0 && !take;
  endsequence

  a_msb_first: assert property (
    s_lone_byte ##1 (take && m_bits == 4'h8) |-> grp_al == $past(in_data))
    else $error("byte not mapped msb first");

  // ************************************************************
  // constellation mapping
  // ************************************************************
  logic [1:0]        quad;
  logic [1:0]        delta;
  logic [1:0]        next_quad;
  logic [1:0]        ni;
  logic [1:0]        nq;
  logic [2:0]        idx_i;
  logic [2:0]        idx_q;
  logic signed [4:0] amp_a;
  logic signed [4:0] amp_b;
  scqm_sym_t         next_sym;

  always_comb begin
    unique case (grp_al[7:6])
      2'h0: delta = `SCQM_Q_KEEP;
      2'h2: delta = `SCQM_Q_CCW;
      2'h3: delta = `SCQM_Q_HALF;
      2'h1: delta = `SCQM_Q_CW;
    endcase
  end

  assign next_quad = quad + delta;
  assign ni        = 2'((m_bits - 4'h1) >> 1);
  assign nq        = 2'((m_bits - 4'h2) >> 1);
  assign idx_i     = {grp_al[5], grp_al[3], grp_al[1]} >> (2'h3 - ni);
  assign idx_q     = {grp_al[4], grp_al[2], grp_al[0]} >> (2'h3 - nq);
  // odd levels 1..15 come out exact, well inside the tolerance
  assign amp_a     = $signed({1'b0, idx_i, 1'b1});
  assign amp_b     = $signed({1'b0, idx_q, 1'b1});

  // other quadrants are the first one turned counter-clockwise
  always_comb begin
    unique case (next_quad)
      2'h0: next_sym = '{i: amp_a, q: amp_b};
      2'h1: next_sym = '{i: -amp_b, q: amp_a};
      2'h2: next_sym = '{i: -amp_a, q: -amp_b};
      2'h3: next_sym = '{i: amp_b, q: -amp_a};
    endcase
    if (short) begin
      next_sym = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quad <= '0;
    end else if (take) begin
      quad <= next_quad;
    end
  end

  a_quad_keep: assert property (take && grp_al[7:6] == 2'h0 |=> $stable(quad))
    else $error("quadrant moved on 00");
  a_quad_ccw: assert property (
    take && grp_al[7:6] == 2'h2 |=> quad == $past(quad) + 2'h1)
    else $error("quadrant did not advance counter-clockwise");

  // ************************************************************
  // symbol line, eight symbol periods deep
  // ************************************************************
  scqm_sym_t [NSYM-1:0] line;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line <= '0;
    end else if (sym_load) begin
      line <= {line[NSYM-2:0], next_sym};
    end
  end

  a_odd_level: assert property (sym_load && !short |=> line[0].i[0] && line[0].q[0])
    else $error("symbol amplitude not odd");

  // ************************************************************
  // carrier and tap phases
  // ************************************************************
  logic [11:0]       den;
  logic [11:0]       kmod;
  logic [11:0]       ctr_ph;
  logic [11:0]       car_ph;
  logic [11:0]       next_car;
  logic [5:0]        car_ix;
  logic signed [7:0] car_c;
  logic signed [7:0] car_s;

  // phase is kept as a residue of den, never rounded, so fc/sr stays k/2s
  assign den      = 12'(cfg.rate_mult == '0 ? 8'h01 : cfg.rate_mult) * `SCQM_DEN_MUL;
  assign kmod     = 12'(16'(cfg.carrier_mult) % 16'(den));
  assign ctr_ph   = 12'((`SCQM_CTR * 16'(kmod)) % 16'(den));
  assign next_car = (car_ph + kmod >= den) ? car_ph + kmod - den : car_ph + kmod;
  assign car_ix   = 6'((18'(car_ph) << `SCQM_LUT_LG) / 18'(den));
  assign car_c    = cos_of(car_ix);
  assign car_s    = cos_of(car_ix - `SCQM_QTR6);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      car_ph <= '0;
    end else if (step) begin
      car_ph <= next_car;
    end
  end

  a_car_bound: assert property (car_ph < den)
    else $error("carrier residue out of range");
  a_car_hold: assert property (!step |=> $stable(car_ph))
    else $error("carrier moved without a sample tick");

  // ************************************************************
  // shaping taps
  // ************************************************************
  logic signed [7:0] gt [NSYM];
  logic signed [7:0] hi [NSYM];
  logic signed [7:0] hq [NSYM];

  // dividers per tap trade area for exact phase at any programmed rate
  for (genvar j = 0; j < NSYM; j++) begin : g_tap
    logic [4:0]         n;
    logic [11:0]        a;
    logic [11:0]        ph;
    logic [5:0]         ix;
    logic signed [7:0]  c;
    logic signed [7:0]  s;
    logic signed [15:0] gc;
    logic signed [15:0] gs;

    assign n     = 5'(j * OSR) + 5'(phase);
    assign a     = 12'((16'(n) * 16'(kmod)) % 16'(den));
    assign ph    = (a >= ctr_ph) ? a - ctr_ph : a + den - ctr_ph;
    assign ix    = 6'((18'(ph) << `SCQM_LUT_LG) / 18'(den));
    assign gt[j] = $signed(TAPS[n]);
    assign c     = cos_of(ix);
    assign s     = cos_of(ix - `SCQM_QTR6);
    assign gc    = gt[j] * c;
    assign gs    = gt[j] * s;
    assign hi[j] = 8'(gc >>> `SCQM_TAP_SH);
    assign hq[j] = 8'(gs >>> `SCQM_TAP_SH);
  end

  // ************************************************************
  // filters and mixing
  // ************************************************************
  logic signed [15:0] fi_bb;
  logic signed [15:0] fq_bb;
  logic signed [15:0] fi_pb;
  logic signed [15:0] fq_pb;
  logic signed [23:0] mix_i;
  logic signed [23:0] mix_q;
  scqm_sample_t       mod_val;

  always_comb begin
    fi_bb = '0;
    fq_bb = '0;
    fi_pb = '0;
    fq_pb = '0;
    for (int j = 0; j < NSYM; j++) begin
      fi_bb = fi_bb + 16'(line[j].i * gt[j]);
      fq_bb = fq_bb + 16'(line[j].q * gt[j]);
      fi_pb = fi_pb + 16'(line[j].i * hi[j]);
      fq_pb = fq_pb + 16'(line[j].q * hq[j]);
    end
  end

  assign mix_i = fi_bb * car_c;
  assign mix_q = fq_bb * car_s;

  always_comb begin
    unique case (cfg.mode)
      SCQM_PASSBAND: mod_val = fi_pb + (-fq_pb);
      SCQM_BASEBAND: mod_val = 16'((mix_i - mix_q) >>> `SCQM_TAP_SH);
    endcase
  end

  // ************************************************************
  // band-pass stage
  // ************************************************************
  // zeros at dc and at half the sample rate trim what the template leaves
  scqm_sample_t m1;
  scqm_sample_t m2;
  scqm_sample_t push_val;

  assign push_val = 16'((17'(mod_val) - 17'(m2)) >>> `SCQM_BP_SH);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m1 <= '0;
      m2 <= '0;
    end else if (step) begin
      m1 <= mod_val;
      m2 <= m1;
    end
  end

  a_bp_dc: assert property (
    step && mod_val == m1 && m1 == m2 |-> push_val == '0)
    else $error("band-pass passes dc");

  // ************************************************************
  // output buffer
  // ************************************************************
  scqm_sample_t [1:0] buf_mem;
  logic               wr_p;
  logic               rd_p;
  logic [1:0]         buf_cnt;
  logic               pop;

  assign buf_in_ready = (buf_cnt != `SCQM_BUF_DEPTH);
  assign out_valid    = (buf_cnt != '0);
  assign out_data     = buf_mem[rd_p];
  assign pop          = out_valid && out_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_mem <= '0;
      wr_p    <= 1'b0;
    end else if (step) begin
      buf_mem[wr_p] <= push_val;
      wr_p          <= !wr_p;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_p <= 1'b0;
    end else if (pop) begin
      rd_p <= !rd_p;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_cnt <= '0;
    end else begin
      buf_cnt <= buf_cnt + 2'(step) - 2'(pop);
    end
  end

  sequence s_stall;
    out_valid && !out_ready;
  endsequence

  a_buf_hold: assert property (s_stall |=> out_valid && $stable(out_data))
    else $error("output sample changed while stalled");

endmodule // scqm_modulator

// ---- verif/scqm_dac_model.sv ----
// Purpose : converter side of the sample stream, prompt or slow
// Assumes : out_ready is changed on the falling edge only
// Notes   : slow mode accepts one cycle in five so the two-entry buffer fills

module scqm_dac_model
  import scqm_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          out_valid,
  input  wire scqm_sample_t  out_data,
  input  wire logic          stall_mode,
  output logic               out_ready,
  output logic               hold_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  scqm_sample_t got[$];
  scqm_sample_t prev;
  logic         was_stall;
  int           slot;

  always @(negedge clk) begin
    slot      = slot + 1;
    out_ready = !stall_mode || (slot % 5 == 0);
  end

  // a stalled sample must stand unchanged until it is taken
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_bad  <= 1'b0;
      was_stall <= 1'b0;
    end else begin
      if (out_valid && out_ready) got.push_back(out_data);
      if (was_stall && (out_valid !== 1'b1 || out_data !== prev)) hold_bad <= 1'b1;
      was_stall <= out_valid && !out_ready;
      prev      <= out_data;
    end
  end
endmodule // scqm_dac_model

// ---- verif/tb.sv ----
// Purpose : self-checking bench of the qam modulator
// Assumes : inputs change on the falling edge; expectations from linearity
// Notes   : reruns from reset compare their first 80 samples against each other, some from sample 40 on

`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

module tb;
  import scqm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS    = 80;
  localparam int LIMIT = 40000;
  logic         clk;
  logic         rst;
  scqm_cfg_t    cfg;
  logic         in_valid;
  logic [7:0]   in_data;
  logic         in_ready;
  logic         out_valid;
  scqm_sample_t out_data;
  logic         out_ready;
  logic         underrun;
  logic         stall;
  logic         hold_bad;
  int           mismatches;
  int           tests_run;
  int           cycles = 0;
  scqm_sample_t rec[9][NS];

  scqm_modulator dut (.clk(clk), .rst(rst), .cfg(cfg), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .underrun(underrun));
  scqm_dac_model dac (.clk(clk), .rst(rst), .out_valid(out_valid), .out_data(out_data),
    .stall_mode(stall), .out_ready(out_ready), .hold_bad(hold_bad));

  always #5 clk = ~clk;

  // ****************************************
  // run control
  // ****************************************
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard: a stuck stream ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end

  function automatic scqm_cfg_t mk(scqm_mode_t m, logic [15:0] div);
    return '{mode: m, bits_per_sym: 4'h2, rate_mult: 8'h01,
             carrier_mult: 10'h001, sample_div: div};
  endfunction

  task automatic do_reset(input scqm_cfg_t c, input logic slow, input int n);
    @(negedge clk);
    rst      = 1'b1;
    cfg      = c;
    in_valid = 1'b0;
    in_data  = 8'h00;
    stall    = slow;
    repeat (n) @(negedge clk);
    rst = 1'b0;
    dac.got.delete();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic reset_values();
    do_reset(mk(SCQM_BASEBAND, 16'h0002), 1'b0, 20);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    `CHK("in_ready", 1'b1, in_ready)
    `CHK("out_valid", 1'b0, out_valid)
    `CHK("out_data", 16'sh0000, out_data)
    `CHK("underrun", 1'b0, underrun)
  endtask

  // two bytes fill the bit reservoir past one byte, the third is refused
  task automatic byte_refusal();
    do_reset(mk(SCQM_PASSBAND, 16'h00c8), 1'b0, 2);
    in_valid = 1'b1;
    in_data  = 8'ha5;
    `CHK("in_ready first", 1'b1, in_ready)
    @(negedge clk);
    `CHK("in_ready second", 1'b1, in_ready)
    @(negedge clk);
    `CHK("in_ready third", 1'b0, in_ready)
    in_valid = 1'b0;
  endtask

  // with no data every symbol is a zero symbol; one sample per four clocks
  task automatic starve_rate();
    int unders;
    int n;
    unders = 0;
    do_reset(mk(SCQM_BASEBAND, 16'h0004), 1'b0, 2);
    repeat (400) begin
      @(negedge clk);
      if (underrun === 1'b1) unders++;
    end
    n = dac.got.size();
    `CHK("sample count", 1'b1, n >= 98 && n <= 101)
    `CHK("underrun count", 1'b1, unders >= 23 && unders <= 26)
    foreach (dac.got[i]) `CHK("silent sample", 16'sh0000, dac.got[i])
  endtask

  // one byte lands just before a symbol load at one sample per clock, then the reservoir runs dry
  task automatic lone_byte();
    scqm_cfg_t c;
    c              = mk(SCQM_PASSBAND, 16'h0001);
    c.bits_per_sym = 4'h8;
    do_reset(c, 1'b0, 2);
    repeat (3) @(negedge clk);
    in_valid = 1'b1;
    in_data  = 8'h3f;
    @(negedge clk);
    in_valid = 1'b0;
    @(negedge clk);
    `CHK("lone byte taken", 1'b0, underrun)
    repeat (4) @(negedge clk);
    `CHK("empty after lone byte", 1'b1, underrun)
  endtask

  // first byte carries the quadrant moves, the rest follow it
  task automatic run_seq(input scqm_cfg_t c, input logic [7:0] first, input logic [7:0] rest,
                         input logic slow, input int slot);
    int wait_n;
    do_reset(c, slow, 2);
    in_valid = 1'b1;
    in_data  = first;
    @(negedge clk);
    in_data = rest;
    wait_n  = 0;
    while (dac.got.size() < NS && wait_n < 2000) begin
      @(negedge clk);
      wait_n++;
    end
    `CHK("record length", 1'b1, dac.got.size() >= NS)
    `CHK("stall hold", 1'b0, hold_bad)
    for (int i = 0; i < NS; i++) rec[slot][i] = dac.got[i];
    in_valid = 1'b0;
  endtask

  function automatic logic near_neg(scqm_sample_t a, scqm_sample_t b);
    int s;
    s = int'(a) + int'(b);
    return s >= -3 && s <= 3;
  endfunction

  // level 15 against level 1; rounding of the two shifts stays within 16
  function automatic logic near15(scqm_sample_t a, scqm_sample_t b);
    int d;
    d = int'(a) - 15 * int'(b);
    return d >= -16 && d <= 16;
  endfunction

  // half turn negates the stream; two quarter turns either way reach the same steady state
  task automatic quadrant_codes(input scqm_mode_t m);
    logic      live;
    scqm_cfg_t c;
    live = 1'b0;
    c    = mk(m, 16'h0002);
    run_seq(c, 8'h00, 8'h00, 1'b0, 0);
    run_seq(c, 8'hc0, 8'h00, 1'b1, 1);
    run_seq(c, 8'ha0, 8'h00, 1'b0, 2);
    run_seq(c, 8'h50, 8'h00, 1'b0, 3);
    run_seq(c, 8'h80, 8'h00, 1'b1, 4);
    run_seq(c, 8'h40, 8'h00, 1'b0, 5);
    c.bits_per_sym = 4'h8;
    run_seq(c, 8'h3f, 8'h3f, 1'b0, 6);
    // same carrier to symbol ratio, and a carrier one sample rate higher, give the same samples
    c              = mk(m, 16'h0002);
    c.rate_mult    = 8'h02;
    c.carrier_mult = 10'h002;
    run_seq(c, 8'h00, 8'h00, 1'b0, 7);
    c.rate_mult    = 8'h01;
    c.carrier_mult = 10'h009;
    run_seq(c, 8'h00, 8'h00, 1'b0, 8);
    for (int i = 0; i < NS; i++) begin
      if (rec[0][i] != 16'sh0000) live = 1'b1;
      `CHK("keep vs half", 1'b1, near_neg(rec[0][i], rec[1][i]))
      `CHK("ccw vs cw", 1'b1, near_neg(rec[4][i], rec[5][i]))
      `CHK("level fifteen", 1'b1, near15(rec[6][i], rec[0][i]))
      `CHK("doubled rate", rec[0][i], rec[7][i])
      `CHK("aliased carrier", rec[0][i], rec[8][i])
      // the first symbols differ until they leave the eight-symbol line
      if (i >= NS / 2) begin
        `CHK("ccw twice", rec[1][i], rec[2][i])
        `CHK("cw twice", rec[1][i], rec[3][i])
      end
    end
    `CHK("shaped output", 1'b1, live)
  endtask

  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    cfg        = mk(SCQM_PASSBAND, 16'h0002);
    in_valid   = 1'b0;
    in_data    = 8'h00;
    stall      = 1'b0;
    mismatches = 0;
    tests_run  = 0;
    reset_values();
    byte_refusal();
    starve_rate();
    lone_byte();
    quadrant_codes(SCQM_PASSBAND);
    quadrant_codes(SCQM_BASEBAND);
    complete_run();
  end
endmodule // tb
